// ### logic/tlpc_codec.sv
// media pulse encoder and decoder with framing and backplane clock
`timescale 1ns/10ps
`default_nettype none
module tlpc_codec
   import tlpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic backplane_mode,
   input wire logic driver_style_select,
   input wire tlpc_word_t tx_word,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic tx_busy,
   output logic line_pulse_a_n,
   output logic line_pulse_a_oe,
   output logic line_pulse_b_n,
   input wire logic line_pulse_b_in,
   output logic transmit_enable_out,
   input wire logic line_receive_in,
   output logic rx_bit,
   output logic rx_bit_valid
);
   tlpc_word_t bw;
   logic bvalid, bready;

   // -------------------------------------------------
   // input buffer
   // -------------------------------------------------
   tlpc_buf2 u_buf (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .in_word(tx_word),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_word(bw),
      .out_valid(bvalid),
      .out_ready(bready)
   );

   function automatic logic hyb_pulse(input logic [4:0] ph, input logic lo,
                                      input logic [4:0] hi);
      hyb_pulse = (ph >= {4'h0, lo}) && (ph < hi);
   endfunction

   // -------------------------------------------------
   // strap capture after reset release
   // -------------------------------------------------
   logic strap_done_r, strap_done_nxt;
   logic transmit_enable_out_high_r, transmit_enable_out_high_nxt;
   always_comb begin
      strap_done_nxt = 1'b1;
      transmit_enable_out_high_nxt = transmit_enable_out_high_r;
      if (!strap_done_r) begin
         transmit_enable_out_high_nxt = !line_pulse_b_in;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_done_r <= 1'b0;
         transmit_enable_out_high_r <= 1'b0;
      end else if (ce) begin
         strap_done_r <= strap_done_nxt;
         transmit_enable_out_high_r <= transmit_enable_out_high_nxt;
      end
   end

   // -------------------------------------------------
   // transmit framing state machine
   // -------------------------------------------------
   tlpc_state_t st_r, st_nxt;
   logic [4:0] ph_r, ph_nxt;
   logic [3:0] ui_r, ui_nxt;
   tlpc_word_t cur_r, cur_nxt;
   logic bit_r, bit_nxt;
   logic pop;
   always_comb begin
      logic ui_end;
      ui_end = (ph_r == UI_LAST);
      st_nxt = st_r;
      ph_nxt = ui_end ? 5'h00 : ph_r + 5'h01;
      ui_nxt = ui_r;
      cur_nxt = cur_r;
      bit_nxt = bit_r;
      pop = 1'b0;
      unique case (st_r)
         TLPC_IDLE: begin
            ph_nxt = 5'h00;
            bit_nxt = 1'b0;
            if (bvalid && strap_done_r) begin
               st_nxt = TLPC_ALERT;
               ui_nxt = 4'h0;
               bit_nxt = 1'b1;
            end
         end
         TLPC_ALERT: begin
            if (ui_end) begin
               ui_nxt = ui_r + 4'h1;
               bit_nxt = 1'b1;
               if (ui_r == ALERT_UI_W - 4'h1) begin
                  st_nxt = TLPC_CHAR;
                  ui_nxt = 4'h0;
                  cur_nxt = bw;
                  pop = 1'b1;
               end
            end
         end
         TLPC_CHAR: begin
            if (ui_end) begin
               ui_nxt = ui_r + 4'h1;
               // two marks, one space, eight data lsb first
               if (ui_nxt < LEAD_MARK_W) begin
                  bit_nxt = 1'b1;
               end else if (ui_nxt == LEAD_MARK_W) begin
                  bit_nxt = 1'b0;
               end else if (ui_nxt < CHAR_UI_W) begin
                  bit_nxt = cur_r.data[3'(ui_nxt - 4'h3)];
               end
               if (ui_r == CHAR_UI_W - 4'h1) begin
                  ui_nxt = 4'h0;
                  bit_nxt = 1'b1;
                  if (cur_r.last || !bvalid) begin
                     st_nxt = TLPC_IDLE;
                     bit_nxt = 1'b0;
                  end else begin
                     cur_nxt = bw;
                     pop = 1'b1;
                  end
               end
            end
         end
         default: st_nxt = TLPC_IDLE;
      endcase
   end
   assign bready = pop;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= TLPC_IDLE;
         ph_r <= 5'h00;
         ui_r <= 4'h0;
         cur_r <= '0;
         bit_r <= 1'b0;
      end else if (ce) begin
         st_r <= st_nxt;
         ph_r <= ph_nxt;
         ui_r <= ui_nxt;
         cur_r <= cur_nxt;
         bit_r <= bit_nxt;
      end
   end

   // -------------------------------------------------
   // pulse shaping, registered line outputs
   // -------------------------------------------------
   tlpc_line_t line_r, line_nxt;
   always_comb begin
      logic act;
      logic one;
      act = (st_nxt != TLPC_IDLE);
      one = act && bit_nxt;
      line_nxt.pulse_a_oe = 1'b1;
      line_nxt.pulse_b_n = 1'b1;
      line_nxt.transmit_enable_out_level = act;
      if (!backplane_mode) begin
         // dipulse halves inside one interval
         line_nxt.pulse_a_n =
            !(one && hyb_pulse(ph_nxt, 1'b0, HYB_END));
         line_nxt.pulse_b_n = !(one && (ph_nxt >= HYB_END) &&
                                (ph_nxt < HYB_B_END));
      end else begin
         line_nxt.pulse_a_n = !(one && (ph_nxt < BP_END));
         // open drain drives only the low half
         line_nxt.pulse_a_oe = driver_style_select || !line_nxt.pulse_a_n;
         line_nxt.pulse_b_n = act ? (ph_nxt < BP_CLK_HALF) : 1'b1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         line_r <= '{pulse_a_n: 1'b1, pulse_a_oe: 1'b0,
                     pulse_b_n: 1'b1, transmit_enable_out_level: 1'b0};
      end else if (ce) begin
         line_r <= line_nxt;
      end
   end
   assign line_pulse_a_n = line_r.pulse_a_n;
   assign line_pulse_a_oe = line_r.pulse_a_oe;
   assign line_pulse_b_n = line_r.pulse_b_n;
   // enable polarity only follows the strap in backplane mode
   assign transmit_enable_out = (backplane_mode && transmit_enable_out_high_r) ?
      line_r.transmit_enable_out_level : !line_r.transmit_enable_out_level;
   assign tx_busy = (st_r != TLPC_IDLE);

   // -------------------------------------------------
   // receive decoder: pulse seen in window is a one
   // -------------------------------------------------
   logic [4:0] rph_r, rph_nxt;
   logic seen_r, seen_nxt, prev_r, prev_nxt;
   logic rbit_r, rbit_nxt, rval_r, rval_nxt;
   always_comb begin
      logic act_lvl;
      logic edge_in;
      act_lvl = backplane_mode ? !line_receive_in : line_receive_in;
      edge_in = act_lvl && !prev_r;
      prev_nxt = act_lvl;
      rph_nxt = (rph_r == UI_LAST) ? 5'h00 : rph_r + 5'h01;
      seen_nxt = seen_r;
      rbit_nxt = rbit_r;
      rval_nxt = 1'b0;
      // decide the old cell even when a new pulse arrives in the same clock
      if (rph_r == RX_WIN) begin
         rbit_nxt = seen_r;
         rval_nxt = 1'b1;
         seen_nxt = 1'b0;
      end
      if (edge_in) begin
         // resync cell so the pulse lands at jitter offset
         rph_nxt = 5'(JIT_CYC);
         seen_nxt = 1'b1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rph_r <= 5'h00;
         seen_r <= 1'b0;
         prev_r <= 1'b0;
         rbit_r <= 1'b0;
         rval_r <= 1'b0;
      end else if (ce) begin
         rph_r <= rph_nxt;
         seen_r <= seen_nxt;
         prev_r <= prev_nxt;
         rbit_r <= rbit_nxt;
         rval_r <= rval_nxt;
      end
   end
   assign rx_bit = rbit_r;
   assign rx_bit_valid = rval_r;

   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   hyb_nonoverlap_a: assert property (@(posedge clk) disable iff (rst)
      !(line_pulse_a_n == 1'b0 && line_pulse_b_n == 1'b0))
      else $error("pulse outputs overlap");
   hyb_width_a: assert property (@(posedge clk) disable iff (rst)
      (!backplane_mode && ce && $fell(line_pulse_a_n)) |->
      (!line_pulse_a_n) [*4] ##1 line_pulse_a_n)
      else $error("hybrid pulse width wrong");
   hyb_b_order_a: assert property (@(posedge clk) disable iff (rst)
      (!backplane_mode && ce && $fell(line_pulse_b_n)) |->
      $past(!line_pulse_a_n)) else $error("pulse b without pulse a");
   bp_width_a: assert property (@(posedge clk) disable iff (rst)
      (backplane_mode && ce && $fell(line_pulse_a_n)) |->
      (!line_pulse_a_n) [*8] ##1 line_pulse_a_n)
      else $error("backplane pulse width wrong");
   od_style_a: assert property (@(posedge clk) disable iff (rst)
      (backplane_mode && !driver_style_select && line_pulse_a_n &&
       $stable(driver_style_select) && $stable(backplane_mode))
      |-> !line_pulse_a_oe) else $error("open drain drives high");
   idle_quiet_a: assert property (@(posedge clk) disable iff (rst)
      (st_r == TLPC_IDLE && $past(st_r) == TLPC_IDLE) |->
      line_pulse_a_n && !line_r.transmit_enable_out_level) else $error("idle line active");
   alert_len_a: assert property (@(posedge clk) disable iff (rst)
      (ce && st_r == TLPC_ALERT && ph_r == UI_LAST) |->
      (ui_r < ALERT_UI_W)) else $error("alert too long");
   rx_sample_a: assert property (@(posedge clk) disable iff (rst)
      (ce && seen_r && rph_r == RX_WIN) |=> (rx_bit && rx_bit_valid))
      else $error("seen pulse not decoded");
   cell_phase_a: assert property (@(posedge clk) disable iff (rst)
      (ce && !line_pulse_a_n) |-> (ph_r < BP_END))
      else $error("pulse outside interval");
   cover_hyb_c: cover property (@(posedge clk) disable iff (rst)
      !backplane_mode && $fell(line_pulse_b_n));
   cover_bp_c: cover property (@(posedge clk) disable iff (rst)
      backplane_mode && $fell(line_pulse_a_n));
   cover_char_c: cover property (@(posedge clk) disable iff (rst)
      st_r == TLPC_CHAR && st_nxt == TLPC_IDLE);
   cover_rx_c: cover property (@(posedge clk) disable iff (rst)
      rx_bit_valid && rx_bit);
endmodule
`default_nettype wire

// ### pkg/tlpc_pkg.sv
// package for the media pulse codec: timing, states and carrier structs
package tlpc_pkg;
   // clock and unit interval
   localparam int CLK_NS = 25;
   localparam int UI_NS = 400;
   localparam int HYB_PULSE_NS = 100;
   localparam int BP_PULSE_NS = 200;
   localparam int JITTER_NS = 100;
   localparam int UI_CYC = UI_NS / CLK_NS;
   localparam int HYB_CYC = HYB_PULSE_NS / CLK_NS;
   localparam int BP_CYC = BP_PULSE_NS / CLK_NS;
   localparam int JIT_CYC = JITTER_NS / CLK_NS;
   // framing counts
   localparam int ALERT_UI = 6;
   localparam int LEAD_MARK_UI = 2;
   localparam int CHAR_UI = 11;
   localparam logic [3:0] ALERT_UI_W = 4'h6;
   localparam logic [3:0] CHAR_UI_W = 4'hb;
   localparam logic [3:0] LEAD_MARK_W = 4'h2;
   localparam logic [4:0] UI_LAST = 5'h0f;
   localparam logic [4:0] HYB_END = 5'h04;
   localparam logic [4:0] HYB_B_END = 5'h08;
   localparam logic [4:0] BP_END = 5'h08;
   localparam logic [4:0] BP_CLK_HALF = 5'h08;
   // decision point eight clocks after a resync edge, so that the next pulse
   // may come as early as half a cell later and still land in its own cell
   localparam logic [4:0] RX_WIN = 5'h0b;

   typedef enum logic [1:0] {
      TLPC_IDLE  = 2'b00,
      TLPC_ALERT = 2'b01,
      TLPC_CHAR  = 2'b10
   } tlpc_state_t;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } tlpc_word_t;

   typedef struct packed {
      logic pulse_a_n;
      logic pulse_a_oe;
      logic pulse_b_n;
      logic transmit_enable_out_level;
   } tlpc_line_t;
endpackage

// ### logic/tlpc_buf2.sv
// two-entry buffer between the byte source and the serialiser
`timescale 1ns/10ps
`default_nettype none
module tlpc_buf2
   import tlpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire tlpc_word_t in_word,
   input wire logic in_valid,
   output logic in_ready,
   output tlpc_word_t out_word,
   output logic out_valid,
   input wire logic out_ready
);
   tlpc_word_t mem_r [2];
   tlpc_word_t mem_nxt [2];
   logic [1:0] cnt_r, cnt_nxt;
   logic rd_r, rd_nxt;
   logic wr_r, wr_nxt;

   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_word = mem_r[rd_r];

   // -------------------------------------------------
   // pointer and count update
   // -------------------------------------------------
   always_comb begin
      logic push;
      logic pop;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      mem_nxt = mem_r;
      cnt_nxt = cnt_r;
      rd_nxt = rd_r;
      wr_nxt = wr_r;
      if (push) begin
         mem_nxt[wr_r] = in_word;
         wr_nxt = ~wr_r;
      end
      if (pop) begin
         rd_nxt = ~rd_r;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 2'h1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 2'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         cnt_r <= 2'h0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
      end else if (ce) begin
         mem_r <= mem_nxt;
         cnt_r <= cnt_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
      end
   end

   overflow_guard_a: assert property (@(posedge clk) disable iff (rst)
      cnt_r <= 2'h2) else $error("buffer count above two");
endmodule
`default_nettype wire

// ### sim/tlpc_line_model.sv
// line-side model: media pull-up, pulse b strap and receive pulses
`timescale 1ns/10ps
`default_nettype none
module tlpc_line_model
   import tlpc_pkg::*;
(
   input wire logic clk,
   input wire logic backplane_mode,
   input wire logic strap_gnd,
   input wire logic pulse_a_n,
   input wire logic pulse_a_oe,
   input wire logic pulse_b_n,
   output logic pulse_b_in,
   output logic media,
   output logic receive_in
);
   // ------------------------------
   // pins seen by the device
   // ------------------------------
   // one pull-up on the media holds it high unless a node pulls low
   assign media = (pulse_a_oe && !pulse_a_n) ? 1'b0 : 1'b1;
   // grounded strap reads low, an open pin follows the device output
   assign pulse_b_in = strap_gnd ? 1'b0 : pulse_b_n;
   initial receive_in = 1'b0;
   // one cell of 16 clocks, a 2-clock pulse moved by jit
   task automatic send_bit(input logic b, input int jit);
      for (int i = 0; i < UI_CYC; i++) begin
         @(posedge clk);
         #2;
         receive_in = (b && (i == 4 + jit || i == 5 + jit)) ^ backplane_mode;
      end
   endtask
endmodule
`default_nettype wire

// ### sim/token_lan_media_pulse_codec_test.sv
// self-checking bench for the media pulse codec
`timescale 1ns/10ps
`default_nettype none
module token_lan_media_pulse_codec_test;
   import tlpc_pkg::*;
   logic clk, rst, ce, backplane_mode, driver_style_select, tx_valid;
   logic tx_ready, tx_busy, pa_n, pa_oe, pb_n, pb_in, te_out, rx_in;
   logic rx_bit, rx_bit_valid, strap_gnd, media;
   tlpc_word_t tx_word;
   logic [7:0] bytes [4];
   logic [15:0] lfsr = 16'h7155;
   int mismatches = 0;
   int cmp_count = 0;
   int refused;
   // ------------------------------
   // device, line model and clock
   // ------------------------------
   tlpc_codec dut (.clk(clk), .rst(rst), .ce(ce),
      .backplane_mode(backplane_mode),
      .driver_style_select(driver_style_select), .tx_word(tx_word),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_busy(tx_busy),
      .line_pulse_a_n(pa_n), .line_pulse_a_oe(pa_oe),
      .line_pulse_b_n(pb_n), .line_pulse_b_in(pb_in),
      .transmit_enable_out(te_out), .line_receive_in(rx_in),
      .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid));
   tlpc_line_model line (.clk(clk), .backplane_mode(backplane_mode),
      .strap_gnd(strap_gnd), .pulse_a_n(pa_n), .pulse_a_oe(pa_oe),
      .pulse_b_n(pb_n), .pulse_b_in(pb_in), .media(media),
      .receive_in(rx_in));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction
   // expected mark or space of unit interval u of the frame
   function automatic logic ui_bit(input int u);
      int k;
      if (u < ALERT_UI) return 1'b1;
      k = (u - ALERT_UI) % CHAR_UI;
      if (k < LEAD_MARK_UI) return 1'b1;
      if (k == LEAD_MARK_UI) return 1'b0;
      return bytes[(u - ALERT_UI) / CHAR_UI][k - 3];
   endfunction
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask
   task automatic do_reset(input logic strap);
      strap_gnd = strap;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      chk("reset lines", 16'h000b, {12'h000, pa_n, pa_oe, pb_n, te_out});
      #2 rst = 1'b0;
      repeat (3) @(posedge clk);
      #2;
   endtask
   // holds the word until an edge sees ready; valid stays up after
   task automatic push(input tlpc_word_t w);
      logic r;
      tx_word = w;
      tx_valid = 1'b1;
      do begin
         r = tx_ready;
         if (r !== 1'b1) refused++;
         @(posedge clk);
         #2;
      end while (r !== 1'b1);
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic frame(input logic bp, input logic od, input int nb);
      logic [15:0] am, bm, mm, ea;
      logic b, act;
      int n;
      backplane_mode = bp;
      driver_style_select = !od;
      act = bp & strap_gnd;
      refused = 0;
      for (int i = 0; i < nb; i++) bytes[i] = rnd();
      fork
         begin
            for (int i = 0; i < nb; i++) push({bytes[i], i == nb - 1});
            tx_valid = 1'b0;
         end
         begin
            n = 0;
            while (pa_n !== 1'b0 && n < 50) begin
               @(posedge clk);
               #2;
               n++;
            end
            for (int u = 0; u < ALERT_UI + CHAR_UI * nb; u++) begin
               b = ui_bit(u);
               chk("enable on", {15'h0000, act}, {15'h0000, te_out});
               for (int j = 0; j < UI_CYC; j++) begin
                  am[j] = !pa_n;
                  bm[j] = !pb_n;
                  mm[j] = !media;
                  if (bp) chk("drive", {15'h0000, od ? !pa_n : 1'b1}, {15'h0000, pa_oe});
                  @(posedge clk);
                  #2;
               end
               ea = b ? (bp ? 16'h00ff : 16'h000f) : 16'h0000;
               chk("pulse a", ea, am);
               chk("pulse b", bp ? 16'hff00 : (b ? 16'h00f0 : 16'h0000),
                   bm);
               if (bp) chk("media", ea, mm);
            end
            repeat (20) @(posedge clk);
            #2;
            chk("idle", {13'h0000, !act, 2'h3}, {12'h000, tx_busy, te_out, pa_n, pb_n});
         end
      join
      if (nb > 3) chk("refused", 16'h0001, {15'h0000, refused > 0});
      $display("test frame mode %0d done", bp);
   endtask
   // random bits with random shift up to one quarter cell either way
   task automatic rx_test(input logic bp);
      logic [15:0] sent, got;
      int k;
      logic seen;
      backplane_mode = bp;
      sent = {rnd(), rnd() | 8'h01};
      got = 16'h0000;
      k = 0;
      seen = 1'b0;
      fork
         begin
            repeat (2) line.send_bit(1'b0, 0);
            for (int i = 0; i < 16; i++) line.send_bit(sent[i], int'(rnd() % 8'h09) - 4);
            repeat (2) line.send_bit(1'b0, 0);
         end
         begin
            repeat (2 * UI_CYC) @(posedge clk);
            repeat (18 * UI_CYC) begin
               @(posedge clk);
               #2;
               if (rx_bit_valid === 1'b1) begin
                  if (rx_bit === 1'b1) seen = 1'b1;
                  if (seen && k < 16) begin
                     got[k] = rx_bit;
                     k++;
                  end
               end
            end
         end
      join
      chk("rx bits", sent, got);
      $display("test receive mode %0d done", bp);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("No errors found");
      end
      else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // main sequence; hybrid is used only at this 2.5 Mbps rate
   initial begin
      ce = 1'b1;
      backplane_mode = 1'b0;
      driver_style_select = 1'b0;
      tx_valid = 1'b0;
      tx_word = '0;
      do_reset(1'b0);
      rx_test(1'b0);
      frame(1'b0, 1'b0, 2);
      frame(1'b1, 1'b1, 4);
      do_reset(1'b1);
      frame(1'b1, 1'b0, 1);
      rx_test(1'b1);
      end_of_test();
   end
   // watchdog: several times the expected run of about 2300 cycles
   initial begin
      #(25 * 10000);
      mismatches++;
      end_of_test();
   end
endmodule
`default_nettype wire
